// ### hrs_host_model.sv
// Host side model: makes the bus clock and drives the hardware reset pin.
// Assumes the bench calls pulse_rst from its own process.
`timescale 1ns/10ps
`default_nettype none

module hrs_host_model
(
  input  wire logic run_i,
  output logic      bus_clk_o,
  output logic      rst_pin_n_o
);
  // ---------------------------------------------------------------------------
  // Bus clock, 160 ns, stands low while not running.
  // ---------------------------------------------------------------------------
  initial
  begin
    bus_clk_o   = 1'b0;
    rst_pin_n_o = 1'b1;
    forever
    begin
      #80;
      bus_clk_o = run_i ? ~bus_clk_o : 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Reset pulse; short values are used on purpose to provoke host faults.
  // ---------------------------------------------------------------------------
  task automatic pulse_rst(input int low_ns, input int high_ns);
    rst_pin_n_o = 1'b0;
    #(low_ns);
    rst_pin_n_o = 1'b1;
    #(high_ns);
  endtask
endmodule // hrs_host_model

`default_nettype wire

// ### hrs_pkg.sv
// Package for the hardware reset and return strobe sequencer, plus its pin synchroniser.
// Assumes one core clock at 100 MHz; every pin input comes from outside that domain.

// ----------------------------------------------------------------------------
// Shared constants and types
// ----------------------------------------------------------------------------
package hrs_pkg;
  localparam int CLK_MHZ          = 100;
  localparam int RST_LOW_US       = 1;
  localparam int RST_HIGH_US      = 1;
  localparam int RST_CMD_US       = 200;
  // Minimum times round up; whole microseconds at an integer MHz rate are exact.
  localparam int RESET_LOW_WIDTH_CYC         = RST_LOW_US * CLK_MHZ;
  localparam int RESET_HIGH_INTERVAL_CYC     = RST_HIGH_US * CLK_MHZ;
  localparam int RESET_TO_COMMAND_DELAY_CYC  = RST_CMD_US * CLK_MHZ;
  localparam int BUS_CLK_MIN      = 74;
  localparam int DLY_W            = 15;
  localparam int WID_W            = 8;
  localparam int BCNT_W           = 7;

  typedef struct packed {
    logic resp;
    logic rd_data;
    logic crc_status;
  } hrs_strobe_req_t;

  typedef struct packed {
    logic in_reset;
    logic cmd_ready;
    logic short_low;
    logic short_high;
  } hrs_status_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HOLD,
    ST_INIT
  } hrs_state_t;
endpackage

`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------------
// Two-flop synchroniser with edge detection on the settled copy
// ----------------------------------------------------------------------------
module hrs_pin_sync
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  input  wire logic d_i,
  output logic      q_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // The first stage feeds only the second; edges are taken from settled stages.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= '0;
    end
    else if (en_i)
    begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign q_o    = sync_ff;
  assign rise_o = sync_ff & ~last_ff;
  assign fall_o = ~sync_ff & last_ff;
endmodule // hrs_pin_sync

`default_nettype wire

// ### hrs_reset_seq.sv
// Hardware reset sequencer and return strobe gating for a managed flash device.
// Assumes the host drives the reset pin and bus clock; core flags arrive on clk_i.
// Behaviour
// - In the fastest DDR mode every command response is accompanied by a toggling return strobe.
// - Outside that mode the strobe stays idle; in it, read data and CRC status tokens toggle it too.
// - The internal reset sequence starts on the rising edge of the reset line, not its fall.
// - Before the enable setting is loaded after power-on the reset line may be ignored.

`timescale 1ns/10ps
`default_nettype none

module hrs_reset_seq
#(
  parameter int RESET_TO_COMMAND_DELAY_CYC = hrs_pkg::RESET_TO_COMMAND_DELAY_CYC,
  parameter int BUS_CLK_MIN                = hrs_pkg::BUS_CLK_MIN
)
(
  input  wire logic                    clk_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    en_i,
  input  wire logic                    rst_pin_n_i,
  input  wire logic                    bus_clk_i,
  input  wire logic                    rst_pin_enable_i,
  input  wire logic                    cfg_loaded_i,
  input  wire logic                    hs400_i,
  input  wire hrs_pkg::hrs_strobe_req_t strobe_req_i,
  output logic                         dev_reset_o,
  output hrs_pkg::hrs_status_t         status_o,
  output logic                         return_strobe_o,
  output logic                         return_strobe_oe_o
);

  // --------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // --------------------------------------------------------------------------
  localparam logic [hrs_pkg::DLY_W-1:0]  DLY_END  =
    hrs_pkg::DLY_W'(RESET_TO_COMMAND_DELAY_CYC);
  localparam logic [hrs_pkg::BCNT_W-1:0] BCLK_END = hrs_pkg::BCNT_W'(BUS_CLK_MIN);
  localparam logic [hrs_pkg::WID_W-1:0]  LOW_END  =
    hrs_pkg::WID_W'(hrs_pkg::RESET_LOW_WIDTH_CYC);
  localparam logic [hrs_pkg::WID_W-1:0]  HIGH_END =
    hrs_pkg::WID_W'(hrs_pkg::RESET_HIGH_INTERVAL_CYC);

  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta_ff <= '0;
      rst_n_ff    <= '0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  logic pin_lvl;
  logic pin_rise;
  logic pin_fall;
  logic bclk_lvl;
  logic bclk_rise;

  hrs_pin_sync u_rst_sync
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_ff),
    .en_i    (en_i),
    .d_i     (rst_pin_n_i),
    .q_o     (pin_lvl),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  hrs_pin_sync u_bclk_sync
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_ff),
    .en_i    (en_i),
    .d_i     (bus_clk_i),
    .q_o     (bclk_lvl),
    .rise_o  (bclk_rise),
    .fall_o  ()
  );

  // --------------------------------------------------------------------------
  // Reset sequence state
  // --------------------------------------------------------------------------
  hrs_pkg::hrs_state_t state_ff;
  hrs_pkg::hrs_state_t nxt_state;
  logic [hrs_pkg::DLY_W-1:0]  dly_cnt_ff;
  logic [hrs_pkg::BCNT_W-1:0] bclk_cnt_ff;
  logic [hrs_pkg::WID_W-1:0]  low_cnt_ff;
  logic [hrs_pkg::WID_W-1:0]  high_cnt_ff;
  logic                       armed;
  logic                       init_done;
  logic                       reset_start;

  // A pin left disabled, or an unloaded setting, must not disturb a running device.
  assign armed       = rst_pin_enable_i & cfg_loaded_i;
  assign init_done   = (dly_cnt_ff >= DLY_END) & (bclk_cnt_ff >= BCLK_END);
  assign reset_start = (state_ff == hrs_pkg::ST_HOLD) & pin_rise;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      hrs_pkg::ST_RUN:
        if (armed && pin_fall)
          nxt_state = hrs_pkg::ST_HOLD;
      hrs_pkg::ST_HOLD:
        if (pin_rise)
          nxt_state = hrs_pkg::ST_INIT;
        else if (!armed)
          nxt_state = hrs_pkg::ST_RUN;
      hrs_pkg::ST_INIT:
        if (armed && pin_fall)
          nxt_state = hrs_pkg::ST_HOLD;
        else if (init_done)
          nxt_state = hrs_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      state_ff <= hrs_pkg::ST_RUN;
    else if (en_i)
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      dev_reset_o <= '0;
    else if (en_i)
      dev_reset_o <= reset_start;
  end

  // Command delay and bus clock count run from the release edge onward.
  always_ff @(posedge clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      dly_cnt_ff  <= '0;
      bclk_cnt_ff <= '0;
    end
    else if (en_i)
    begin
      if (state_ff != hrs_pkg::ST_INIT)
      begin
        dly_cnt_ff  <= '0;
        bclk_cnt_ff <= '0;
      end
      else
      begin
        if (dly_cnt_ff < DLY_END)
          dly_cnt_ff <= dly_cnt_ff + 1'b1;
        if (bclk_rise && bclk_cnt_ff < BCLK_END)
          bclk_cnt_ff <= bclk_cnt_ff + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pulse width watch
  // --------------------------------------------------------------------------
  logic seen_ff;
  logic short_low_ff;
  logic short_high_ff;

  always_ff @(posedge clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      low_cnt_ff  <= '0;
      high_cnt_ff <= '0;
    end
    else if (en_i)
    begin
      if (state_ff != hrs_pkg::ST_HOLD)
        low_cnt_ff <= '0;
      else if (low_cnt_ff < LOW_END)
        low_cnt_ff <= low_cnt_ff + 1'b1;
      if (pin_rise)
        high_cnt_ff <= '0;
      else if (pin_lvl && high_cnt_ff < HIGH_END)
        high_cnt_ff <= high_cnt_ff + 1'b1;
    end
  end

  // These flags only report host faults; the sequence is still honoured.
  always_ff @(posedge clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      seen_ff       <= '0;
      short_low_ff  <= '0;
      short_high_ff <= '0;
    end
    else if (en_i)
    begin
      if (reset_start)
        seen_ff <= 1'b1;
      if (reset_start && low_cnt_ff < LOW_END)
        short_low_ff <= 1'b1;
      if (armed && pin_fall && seen_ff && high_cnt_ff < HIGH_END)
        short_high_ff <= 1'b1;
    end
  end

  assign status_o.in_reset   = (state_ff != hrs_pkg::ST_RUN);
  assign status_o.cmd_ready  = (state_ff == hrs_pkg::ST_RUN);
  assign status_o.short_low  = short_low_ff;
  assign status_o.short_high = short_high_ff;

  // --------------------------------------------------------------------------
  // Return strobe
  // --------------------------------------------------------------------------
  logic strobe_act;

  // The strobe copies the sampled bus clock through one more register, so its edges trail the pin by the sync delay plus one cycle.
  assign strobe_act = hs400_i & (state_ff == hrs_pkg::ST_RUN) &
                      (strobe_req_i.resp | strobe_req_i.rd_data | strobe_req_i.crc_status);

  always_ff @(posedge clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      return_strobe_o    <= '0;
      return_strobe_oe_o <= '0;
    end
    else if (en_i)
    begin
      return_strobe_oe_o <= strobe_act;
      return_strobe_o    <= strobe_act & bclk_lvl;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence seq_release;
    en_i && state_ff == hrs_pkg::ST_HOLD && pin_rise;
  endsequence

  sequence seq_pulse_out;
    dev_reset_o ##0 (state_ff == hrs_pkg::ST_INIT);
  endsequence

  chk_rise_starts_seq: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
    seq_release |=> seq_pulse_out)
    else $error("reset release did not start the sequence");

  chk_fall_no_start: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
    (en_i && !(state_ff == hrs_pkg::ST_HOLD && pin_rise)) |=> !dev_reset_o)
    else $error("internal reset without a rising edge");

  chk_disabled_pin_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
    (!rst_pin_enable_i && state_ff == hrs_pkg::ST_RUN) |=> state_ff == hrs_pkg::ST_RUN)
    else $error("reset pin acted on while disabled");

  chk_unloaded_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
    (!cfg_loaded_i && state_ff == hrs_pkg::ST_RUN) |=> state_ff == hrs_pkg::ST_RUN)
    else $error("reset pin acted on before setting loaded");

  chk_resp_strobe: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
    (en_i && hs400_i && strobe_req_i.resp && state_ff == hrs_pkg::ST_RUN)
      |=> return_strobe_oe_o && (return_strobe_o == $past(bclk_lvl)))
    else $error("response sent without strobe");

  chk_strobe_idle: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
    (en_i && !strobe_act) |=> !return_strobe_oe_o && !return_strobe_o)
    else $error("strobe active outside allowed traffic");

  chk_ready_waits: assert property (@(posedge clk_i) disable iff (!rst_n_ff)
    (en_i && state_ff == hrs_pkg::ST_INIT && nxt_state == hrs_pkg::ST_RUN)
      |-> dly_cnt_ff >= DLY_END && bclk_cnt_ff >= BCLK_END)
    else $error("ready before delay and bus clocks elapsed");

endmodule // hrs_reset_seq

`default_nettype wire

// ### tb.sv
// Self-checking bench for the reset sequencer and return strobe.
// Assumes short delay parameters; the host model owns pin and bus clock.
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam int DLY = 50;
  localparam int BCN = 4;
  logic clk, arst_n, en, pin_en, loaded, hs400, run, bclk, pin_n, dev_rst, ds, ds_oe;
  logic ds_prev = 1'b0;
  hrs_pkg::hrs_strobe_req_t req;
  hrs_pkg::hrs_status_t     st;
  logic [1:0] rq_q[$];
  logic       sq_q[$];
  int errors, tests_run, toggles, n;

  hrs_host_model u_host (.run_i(run), .bus_clk_o(bclk), .rst_pin_n_o(pin_n));
  hrs_reset_seq #(.RESET_TO_COMMAND_DELAY_CYC(DLY), .BUS_CLK_MIN(BCN)) u_hrs_reset_seq (
    .clk_i(clk), .arst_n_i(arst_n), .en_i(en), .rst_pin_n_i(pin_n), .bus_clk_i(bclk),
    .rst_pin_enable_i(pin_en), .cfg_loaded_i(loaded), .hs400_i(hs400), .strobe_req_i(req),
    .dev_reset_o(dev_rst), .status_o(st), .return_strobe_o(ds), .return_strobe_oe_o(ds_oe));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Monitors: each internal reset pulse and each strobe cycle takes a note.
  // ---------------------------------------------------------------------------
  always @(posedge clk)
  begin
    #1;
    if (dev_rst === 1'b1)
    begin
      if (rq_q.size() == 0)
        chk(2'b11, 2'b00);
      else
      begin
        repeat (8) @(posedge clk);
        chk({st.short_low, st.short_high}, rq_q.pop_front());
      end
    end
  end

  always @(posedge clk)
  begin
    #1;
    if (sq_q.size() > 0)
    begin
      logic e;
      e = sq_q.pop_front();
      chk({1'b0, ds_oe}, {1'b0, e});
      if (!e)
        chk({1'b0, ds}, 2'b00);
      else if (ds !== ds_prev)
        toggles++;
    end
    ds_prev = ds;
  end

  // Host polls cmd_ready on each falling clock edge until it is set, giving up after 400 cycles.
  task automatic wait_ready;
    n = 0;
    while (st.cmd_ready !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk({1'b0, st.cmd_ready}, 2'b01);
  endtask

  initial
  begin
    arst_n = 1'b0;
    {pin_en, loaded, hs400, run} = '0;
    en = 1'b1;
    req = '0;
    errors = 0;
    tests_run = 0;
    toggles = 0;
    void'($urandom(32'hf933));
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    // Pin ignored while the enable or the loaded flag is low, or while the block is frozen.
    for (int i = 0; i < 3; i++)
    begin
      {pin_en, loaded} = (i == 0) ? 2'b01 : ((i == 1) ? 2'b10 : 2'b11);
      en = (i != 2);
      u_host.pulse_rst(1200, 1500);
      @(negedge clk);
      chk({st.in_reset, st.cmd_ready}, 2'b01);
    end
    en = 1'b1;
    $display("test refused pin done");
    // Good pulse; bus clock held still so the busy window cannot end early.
    {pin_en, loaded} = 2'b11;
    rq_q.push_back(2'b00);
    u_host.pulse_rst(1200, 0);
    repeat (10) @(negedge clk);
    chk({st.in_reset, st.cmd_ready}, 2'b10);
    repeat (DLY + 50) @(negedge clk);
    chk({st.in_reset, st.cmd_ready}, 2'b10);
    run = 1'b1;
    wait_ready;
    $display("test good pulse done");
    // Short low pulse, then a fall too soon after the rise.
    rq_q.push_back(2'b10);
    u_host.pulse_rst(300, 300);
    rq_q.push_back(2'b11);
    u_host.pulse_rst(1200, 0);
    wait_ready;
    $display("test host faults done");
    // Random strobe requests across modes.
    for (int i = 0; i < 300; i++)
    begin
      @(negedge clk);
      hs400 = (i < 60) ? 1'b1 : 1'($urandom());
      req = (i < 60) ? 3'b100 : 3'($urandom());
      sq_q.push_back(hs400 & (|req));
    end
    @(negedge clk);
    req = '0;
    repeat (3) @(negedge clk);
    chk({1'b0, toggles > 2}, 2'b01);
    $display("test strobe done");
    print_verdict;
  end

  initial
  begin
    #100us;
    errors++;
    print_verdict;
  end
endmodule // tb

`default_nettype wire
